// ---- temp_readout_test_coil_tb.sv ----
/*
  Self-checking bench: host and device ends joined by the link, driven over Wishbone.
  Assumes the nonvolatile memory answers combinationally; the bench models it.
*/
module temp_readout_test_coil_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import trc_pkg::*;
  localparam logic [7:0] OFFS = 8'hF3; // Arbitrary correction bytes
  localparam logic [7:0] GAIN = 8'h25;
  localparam logic [11:0] COIL_SEQ = 12'h639; // Codes 1,2,3,0,2,1 from bit 0
  logic clk, rst, cyc, stb, wbwe, ack_o, cv, cpos, cneg;
  logic [7:0] adr, otp_addr, otp_rdata;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [14:0] fs, ts;
  int miscompares, tests_run;

  // Nonvolatile memory: correction bytes, a filler elsewhere
  assign otp_rdata = (otp_addr == OTP_TEMP_OFFSET) ? OFFS : ((otp_addr == OTP_TEMP_GAIN) ? GAIN : 8'h5A);
  trc_link_if link (.clk(clk));
  trc_host u_trc_host (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(wbwe), .adr_i(adr),
    .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack_o), .link(link));
  trc_device u_trc_device (.clk(clk), .rst(rst), .link(link), .conv_valid(cv), .field_sample(fs),
    .temp_sample(ts), .otp_addr(otp_addr), .otp_rdata(otp_rdata), .coil_pos(cpos), .coil_neg(cneg));
  trc_link_checker u_trc_link_checker (.clk(clk), .rst(rst), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One classic cycle; the request holds until ack is sampled high, only the watchdog cuts a wait
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbwe <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack_o !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  // Polls busy; a stuck busy runs into the watchdog, which counts it as a fault
  task wait_idle;
    logic [31:0] s;
    do begin
      wb(1'b0, HOST_STATUS, 32'h0, s);
    end while (s[0] !== 1'b0);
  endtask : wait_idle

  task raw_wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, HOST_CMD, {15'h0, 1'b1, d, a}, q);
    wait_idle();
  endtask : raw_wr

  task raw_rd(input logic [7:0] a, output logic [7:0] b);
    logic [31:0] q;
    wb(1'b1, HOST_CMD, {16'h0, 8'h00, a}, q);
    wait_idle();
    wb(1'b0, HOST_CMD, 32'h0, q);
    b = q[7:0];
  endtask : raw_rd

  task rd_pair(input logic [14:0] v);
    logic [7:0] b;
    raw_rd(REG_RESULT_HIGH, b);
    check("result_high", 32'(b), 32'({1'b0, v[14:8]}));
    raw_rd(REG_RESULT_LOW, b);
    check("result_low", 32'(b), 32'(v[7:0]));
  endtask : rd_pair

  // One conversion; results land two cycles after the sample
  task conv(input logic [14:0] f, input logic [14:0] t);
    cv <= 1'b1;
    fs <= f;
    ts <= t;
    @(posedge clk);
    cv <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : conv

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_coil;
    logic [1:0] c;
    logic [31:0] q;
    for (int i = 0; i < 6; i++) begin
      c = COIL_SEQ[2*i +: 2];
      wb(1'b1, HOST_COIL, {30'h0, c}, q);
      wait_idle();
      check("coil_pos", 32'(cpos), 32'(c == COIL_POS));
      check("coil_neg", 32'(cneg), 32'(c == COIL_NEG));
      wb(1'b0, HOST_COIL, 32'h0, q);
      check("coil_code", 32'(q[1:0]), 32'(c));
    end
    $display("t_coil done");
  endtask : t_coil

  // Host code must be the uncorrected combination of the two bytes
  task t_temp;
    logic [31:0] q;
    conv(15'h0100, 15'h5ABC);
    wb(1'b1, HOST_TEMP, 32'h0, q);
    wait_idle();
    wb(1'b0, HOST_TEMP, 32'h0, q);
    check("temp_code", 32'(q[11:0]), 32'(12'(7'h5A * 32 + (8'hBC >> 3))));
    wb(1'b0, HOST_STATUS, 32'h0, q);
    check("temp_valid", 32'(q[1]), 32'h1);
    raw_wr(REG_SOURCE_SEL, 8'h01);
    rd_pair(15'h5ABC);
    $display("t_temp done");
  endtask : t_temp

  // Burst of four: field averaged, temperature is the last sample
  task t_burst;
    raw_wr(REG_BURST, 8'h02);
    conv(15'h0064, 15'h4000);
    conv(15'h00C8, 15'h4800);
    conv(15'h012C, 15'h3000);
    conv(15'h01F4, 15'h4321);
    rd_pair(15'h4321);
    raw_wr(REG_SOURCE_SEL, 8'h00);
    rd_pair(15'h0113);
    raw_wr(REG_BURST, 8'h00);
    raw_wr(REG_TEMPCO, 8'h10);
    conv(15'h0200, 15'h4100);
    rd_pair(15'h0210);
    $display("t_burst done");
  endtask : t_burst

  task t_corr;
    logic [31:0] q;
    logic [7:0] b;
    wb(1'b1, HOST_CORR, 32'h0, q);
    wait_idle();
    wb(1'b0, HOST_CORR, 32'h0, q);
    check("corr_bytes", 32'(q[15:0]), 32'({GAIN, OFFS}));
    // Offset byte differs from the gain byte still latched, so a dead fetch shows
    raw_wr(REG_OTP_ADDR, OTP_TEMP_OFFSET);
    raw_wr(REG_OTP_CTRL, 8'h01);
    raw_rd(REG_OTP_DATA, b);
    check("otp_data", 32'(b), 32'(OFFS));
    raw_rd(REG_OTP_CTRL, b);
    check("otp_trig", 32'(b[0]), 32'h0);
    wb(1'b0, 8'h20, 32'h0, q);
    check("unmapped", q, 32'h0);
    $display("t_corr done");
  endtask : t_corr

  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs a few hundred cycles; this cuts a hang
  initial begin
    #200us;
    miscompares++;
    finish_test();
  end

  initial begin
    {cyc, stb, wbwe, cv} = 4'h0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hF;
    fs = 15'h0;
    ts = 15'h0;
    miscompares = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_coil();
    t_temp();
    t_burst();
    t_corr();
    finish_test();
  end
endmodule : temp_readout_test_coil_tb

// ---- trc_averager.sv ----
/*
  Power-of-two block averager for burst field samples.
  Assumes samples come from logic on the same clock.
*/
module trc_averager #(
  parameter int W = 15
) (
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic in_valid, // Sample strobe
  input wire logic [W-1:0] in_sample, // Sample value
  input wire logic [2:0] log2n, // Burst length exponent
  output logic out_valid, // Average ready pulse
  output logic [W-1:0] out_avg // Averaged value
);
  typedef struct packed {
    logic [W+6:0] acc;
    logic [6:0] cnt;
    logic valid;
    logic [W-1:0] avg;
  } trc_avg_state_type;

  trc_avg_state_type st;
  trc_avg_state_type next_st;
  logic [W+6:0] sum;

  // Accumulate until the burst length is reached, then divide by shifting
  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    sum = st.acc + (W+7)'(in_sample);
    if (in_valid) begin
      if (st.cnt == 7'((7'h01 << log2n) - 7'h01)) begin
        next_st.avg = W'(sum >> log2n);
        next_st.valid = 1'b1;
        next_st.acc = '0;
        next_st.cnt = '0;
      end else begin
        next_st.acc = sum;
        next_st.cnt = st.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_valid = st.valid;
  assign out_avg = st.avg;
endmodule : trc_averager

// ---- trc_device.sv ----
/*
  Device end: result registers, source select, burst averaging with
  temperature compensation, nonvolatile byte fetch and test coil drive.
  Assumes conversion samples and nonvolatile memory are on the same clock,
  and that the memory returns read data combinationally from otp_addr.
*/
module trc_device (
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset
  trc_link_if.device link, // Register link to host
  input wire logic conv_valid, // One conversion done
  input wire logic [14:0] field_sample, // Raw field code
  input wire logic [14:0] temp_sample, // Temperature code of that conversion
  output logic [7:0] otp_addr, // Nonvolatile byte address
  input wire logic [7:0] otp_rdata, // Nonvolatile byte data
  output logic coil_pos, // Coil current positive
  output logic coil_neg // Coil current negative
);
  import trc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] source_sel;
    logic [1:0] test_coil_drive_sel;
    logic coil_pos;
    logic coil_neg;
    logic [2:0] burst_log2;
    logic [7:0] tempco;
    logic [7:0] otp_addr;
    logic [7:0] otp_data;
    logic otp_trig;
    logic [3:0] otp_cnt;
    logic [14:0] field_res;
    logic [14:0] temp_res;
    logic [14:0] temp_last;
    logic pend;
    logic p_we;
    logic [7:0] p_addr;
    logic [7:0] p_wdata;
    logic ack;
    logic [7:0] rdata;
  } trc_dev_state_type;

  trc_dev_state_type st;
  trc_dev_state_type next_st;
  logic avg_valid;
  logic [14:0] avg_field;
  logic signed [15:0] temp_diff;
  logic signed [23:0] corr_prod;
  logic [7:0] res_high;
  logic [7:0] res_low;

  // ----------------------------------------------------------------------
  // Field averaging over a burst
  // ----------------------------------------------------------------------
  trc_averager #(
    .W(15)
  ) u_avg (
    .clk(clk),
    .rst(rst),
    .in_valid(conv_valid),
    .in_sample(field_sample),
    .log2n(st.burst_log2),
    .out_valid(avg_valid),
    .out_avg(avg_field)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    // Compensation uses the latest conversion's temperature
    temp_diff = $signed({1'b0, st.temp_last}) - $signed(TEMP_REF);
    corr_prod = 24'(temp_diff * $signed(st.tempco));
    // Both halves come from the selected source
    if (st.source_sel == SRC_TEMP) begin
      res_high = {1'b0, st.temp_res[14:8]};
      res_low = st.temp_res[7:0];
    end else begin
      res_high = {1'b0, st.field_res[14:8]};
      res_low = st.field_res[7:0];
    end

    // Temperature tracks each conversion; it is never averaged
    if (conv_valid) begin
      next_st.temp_last = temp_sample;
    end
    // Burst end: publish averaged field and the last temperature
    if (avg_valid) begin
      next_st.field_res = avg_field + corr_prod[22:8];
      next_st.temp_res = st.temp_last;
    end

    // Nonvolatile fetch: wait, latch byte, auto-clear trigger
    if (st.otp_trig) begin
      if (st.otp_cnt <= 4'h1) begin
        next_st.otp_data = otp_rdata;
        next_st.otp_trig = 1'b0;
        next_st.otp_cnt = 4'h0;
      end else begin
        next_st.otp_cnt = st.otp_cnt - 4'h1;
      end
    end

    // Coil decode; 11 drives nothing, like 00
    next_st.coil_pos = (st.test_coil_drive_sel == COIL_POS);
    next_st.coil_neg = (st.test_coil_drive_sel == COIL_NEG);

    // Capture a request; served once no fetch is running
    if (link.req) begin
      next_st.pend = 1'b1;
      next_st.p_we = link.we;
      next_st.p_addr = link.addr;
      next_st.p_wdata = link.wdata;
    end
    // A fetch in flight stalls the link so the data read is never stale
    if (st.pend && !st.otp_trig) begin
      next_st.pend = 1'b0;
      next_st.ack = 1'b1;
      next_st.rdata = 8'h00;
      if (st.p_we) begin
        if (st.p_addr == REG_SOURCE_SEL) begin
          next_st.source_sel = st.p_wdata[2:0];
        end else if (st.p_addr == REG_OTP_ADDR) begin
          next_st.otp_addr = st.p_wdata;
        end else if (st.p_addr == REG_OTP_CTRL) begin
          if (st.p_wdata[OTP_TRIG_BIT]) begin
            next_st.otp_trig = 1'b1;
            next_st.otp_cnt = OTP_READ_CYCLES;
          end
        end else if (st.p_addr == REG_COIL) begin
          next_st.test_coil_drive_sel = st.p_wdata[1:0];
        end else if (st.p_addr == REG_BURST) begin
          next_st.burst_log2 = st.p_wdata[2:0];
        end else if (st.p_addr == REG_TEMPCO) begin
          next_st.tempco = st.p_wdata;
        end
      end else begin
        if (st.p_addr == REG_RESULT_HIGH) begin
          next_st.rdata = res_high;
        end else if (st.p_addr == REG_RESULT_LOW) begin
          next_st.rdata = res_low;
        end else if (st.p_addr == REG_SOURCE_SEL) begin
          next_st.rdata = {5'h00, st.source_sel};
        end else if (st.p_addr == REG_OTP_ADDR) begin
          next_st.rdata = st.otp_addr;
        end else if (st.p_addr == REG_OTP_DATA) begin
          next_st.rdata = st.otp_data; // Raw byte, no correction
        end else if (st.p_addr == REG_OTP_CTRL) begin
          next_st.rdata = 8'h00;
        end else if (st.p_addr == REG_COIL) begin
          next_st.rdata = {6'h00, st.test_coil_drive_sel};
        end else if (st.p_addr == REG_BURST) begin
          next_st.rdata = {5'h00, st.burst_log2};
        end else if (st.p_addr == REG_TEMPCO) begin
          next_st.rdata = st.tempco;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.source_sel <= SOURCE_SEL_RESET;
      st.test_coil_drive_sel <= COIL_RESET;
      st.burst_log2 <= BURST_RESET;
      st.tempco <= TEMPCO_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign link.ack = st.ack;
  assign link.rdata = st.rdata;
  assign otp_addr = st.otp_addr;
  assign coil_pos = st.coil_pos;
  assign coil_neg = st.coil_neg;
endmodule : trc_device

// ---- trc_host.sv ----
/*
  Host end: Wishbone classic slave for software, sequencing link accesses
  for raw access, coil change, temperature fetch and correction byte fetch.
  Assumes the device end on the link runs on the same clock.
*/
module trc_host (
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [31:0] dat_i, // Wishbone write data
  input wire logic [3:0] sel_i, // Wishbone byte enables
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  trc_link_if.host link // Register link to device
);
  import trc_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} trc_host_fsm_type;

  typedef struct packed {
    trc_host_fsm_type fsm;
    trc_job_type job;
    logic [2:0] step;
    logic [7:0] cmd_addr;
    logic [7:0] cmd_data;
    logic cmd_we;
    logic [7:0] raw_rdata;
    logic [1:0] coil_now;
    logic [1:0] coil_want;
    logic [7:0] res_high;
    logic [11:0] temp_code;
    logic temp_valid;
    logic [7:0] corr_offset;
    logic [7:0] corr_gain;
    logic corr_valid;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [31:0] dat;
  } trc_host_state_type;

  trc_host_state_type st;
  trc_host_state_type next_st;
  logic op_we;
  logic [7:0] op_addr;
  logic [7:0] op_wdata;
  logic op_last;
  logic op_skip;
  logic wb_req;

  // Step table for each job
  always_comb begin
    op_we = 1'b1;
    op_addr = 8'h00;
    op_wdata = 8'h00;
    op_last = 1'b0;
    op_skip = 1'b0;
    case (st.job)
      JOB_RAW: begin
        op_we = st.cmd_we;
        op_addr = st.cmd_addr;
        op_wdata = st.cmd_data;
        op_last = 1'b1;
      end
      JOB_COIL: begin
        // Go through off when both code bits change: 01<->10, and also 00<->11
        op_addr = REG_COIL;
        if (st.step == 3'h0) begin
          op_wdata = {6'h00, COIL_OFF};
          op_skip = (st.coil_now ^ st.coil_want) != 2'h3;
        end else begin
          op_wdata = {6'h00, st.coil_want};
          op_last = 1'b1;
        end
      end
      JOB_TEMP: begin
        // Select temperature, then read both result bytes
        if (st.step == 3'h0) begin
          op_addr = REG_SOURCE_SEL;
          op_wdata = {5'h00, SRC_TEMP};
        end else begin
          op_we = 1'b0;
          op_addr = (st.step == 3'h1) ? REG_RESULT_HIGH : REG_RESULT_LOW;
          op_last = (st.step == 3'h2);
        end
      end
      default: begin
        // Address, trigger, data, twice
        // Bytes go out raw; software scales them and applies polynomial and supply term
        if (st.step == 3'h0 || st.step == 3'h3) begin
          op_addr = REG_OTP_ADDR;
          op_wdata = (st.step == 3'h0) ? OTP_TEMP_OFFSET : OTP_TEMP_GAIN;
        end else if (st.step == 3'h1 || st.step == 3'h4) begin
          op_addr = REG_OTP_CTRL;
          op_wdata = 8'h01;
        end else begin
          op_we = 1'b0;
          op_addr = REG_OTP_DATA;
          op_last = (st.step == 3'h5);
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.req = 1'b0;
    next_st.ack = 1'b0;
    wb_req = cyc_i && stb_i && !st.ack;

    // Wishbone answers one cycle after the request; start writes while busy are dropped
    if (wb_req) begin
      next_st.ack = 1'b1;
      next_st.dat = 32'h0000_0000;
      if (we_i) begin
        if (sel_i[0] && st.fsm == ST_IDLE) begin
          next_st.fsm = ST_ISSUE;
          next_st.step = 3'h0;
          if (adr_i == HOST_CMD) begin
            next_st.job = JOB_RAW;
            next_st.cmd_addr = dat_i[7:0];
            next_st.cmd_data = dat_i[15:8];
            next_st.cmd_we = dat_i[16];
          end else if (adr_i == HOST_COIL) begin
            next_st.job = JOB_COIL;
            next_st.coil_want = dat_i[1:0];
          end else if (adr_i == HOST_TEMP) begin
            next_st.job = JOB_TEMP;
            next_st.temp_valid = 1'b0;
          end else if (adr_i == HOST_CORR) begin
            next_st.job = JOB_CORR;
            next_st.corr_valid = 1'b0;
          end else begin
            next_st.fsm = ST_IDLE;
          end
        end
      end else begin
        if (adr_i == HOST_CMD) begin
          next_st.dat = {24'h000000, st.raw_rdata};
        end else if (adr_i == HOST_STATUS) begin
          next_st.dat = {29'h0, st.corr_valid, st.temp_valid, st.fsm != ST_IDLE};
        end else if (adr_i == HOST_COIL) begin
          next_st.dat = {30'h0, st.coil_now};
        end else if (adr_i == HOST_TEMP) begin
          next_st.dat = {20'h00000, st.temp_code};
        end else if (adr_i == HOST_CORR) begin
          next_st.dat = {16'h0000, st.corr_gain, st.corr_offset};
        end
      end
    end

    // Link sequencer
    case (st.fsm)
      ST_ISSUE: begin
        if (op_skip) begin
          next_st.step = st.step + 3'h1;
        end else begin
          next_st.req = 1'b1;
          next_st.we = op_we;
          next_st.addr = op_addr;
          next_st.wdata = op_wdata;
          next_st.fsm = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (link.ack) begin
          if (st.job == JOB_RAW) begin
            next_st.raw_rdata = link.rdata;
          end else if (st.job == JOB_COIL) begin
            next_st.coil_now = op_last ? st.coil_want : COIL_OFF;
          end else if (st.job == JOB_TEMP && st.step == 3'h1) begin
            next_st.res_high = link.rdata;
          end else if (st.job == JOB_TEMP && st.step == 3'h2) begin
            // high[6:0]*32 plus low>>3
            next_st.temp_code = {st.res_high[6:0], 5'h00} + 12'(link.rdata >> CODE_LOW_SHIFT);
            next_st.temp_valid = 1'b1;
          end else if (st.job == JOB_CORR && st.step == 3'h2) begin
            next_st.corr_offset = link.rdata;
          end else if (st.job == JOB_CORR && st.step == 3'h5) begin
            next_st.corr_gain = link.rdata;
            next_st.corr_valid = 1'b1; // Kept for software to reuse
          end
          next_st.step = st.step + 3'h1;
          next_st.fsm = op_last ? ST_IDLE : ST_ISSUE;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.fsm <= ST_IDLE;
      st.job <= JOB_RAW;
      st.coil_now <= COIL_RESET;
      st.coil_want <= COIL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign dat_o = st.dat;
  assign ack_o = st.ack;
  assign link.req = st.req;
  assign link.we = st.we;
  assign link.addr = st.addr;
  assign link.wdata = st.wdata;
endmodule : trc_host

// ---- trc_link_checker.sv ----
/*
  Concurrent checks on the register link between the host end and the device end.
  Assumes the testbench hands in the interface signals by name, one clock, synchronous reset.
*/
module trc_link_checker
  import trc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic req, // Link request pulse
  input wire logic we, // Link write
  input wire logic [7:0] addr, // Link address
  input wire logic [7:0] wdata, // Link write data
  input wire logic ack, // Link answer pulse
  input wire logic [7:0] rdata // Link read data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------------
  logic pend;
  logic [1:0] last_coil;

  // Open request and last coil code, so a stray answer shows at the answer and a coil reversal at the next coil write
  always_ff @(posedge clk) begin
    if (rst) begin
      pend <= 1'b0;
      last_coil <= COIL_OFF;
    end else begin
      pend <= req ? 1'b1 : (ack ? 1'b0 : pend);
      last_coil <= (req && we && addr == REG_COIL) ? wdata[1:0] : last_coil;
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_ack_bound;
    req |-> ##[2:8] ack;
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("link answer late");
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("link answer too long");
  property p_one_out;
    req |=> (!req until ack);
  endproperty
  a_one_out: assert property (p_one_out) else $error("second request before answer");
  property p_ack_pend;
    ack |-> pend;
  endproperty
  a_ack_pend: assert property (p_ack_pend) else $error("answer without request");
  property p_addr_hold;
    !req |-> $stable(addr) && $stable(wdata);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved between requests");
  property p_hi_bit7;
    ack && !we && addr == REG_RESULT_HIGH |-> !rdata[7];
  endproperty
  a_hi_bit7: assert property (p_hi_bit7) else $error("result high byte top bit set");
  property p_trig_clear;
    ack && !we && addr == REG_OTP_CTRL |-> !rdata[OTP_TRIG_BIT];
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("fetch trigger not cleared");
  property p_coil_off;
    req && we && addr == REG_COIL |-> !((wdata[1:0] == COIL_POS && last_coil == COIL_NEG)
      || (wdata[1:0] == COIL_NEG && last_coil == COIL_POS));
  endproperty
  a_coil_off: assert property (p_coil_off) else $error("coil reversed without off step");

  // Main traffic kinds
  c_coil: cover property (req && we && addr == REG_COIL);
  c_high: cover property (ack && !we && addr == REG_RESULT_HIGH);
  c_trig: cover property (req && we && addr == REG_OTP_CTRL && wdata[OTP_TRIG_BIT]);
endmodule : trc_link_checker

// ---- trc_link_if.sv ----
/*
  Register link between host end and device end.
  Assumes both ends share clk; req is a one-cycle pulse, ack a one-cycle pulse.
*/
interface trc_link_if (
  input wire logic clk // Shared clock
);
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;

  modport host (input clk, output req, output we, output addr, output wdata, input ack, input rdata);
  modport device (input clk, input req, input we, input addr, input wdata, output ack, output rdata);
endinterface : trc_link_if

// ---- trc_pkg.sv ----
/*
  Constants, types and register map shared by both ends of the temperature
  readout and test coil link, and by the Wishbone side of the host end.
  Assumes a single 100 MHz clock for both ends and a synchronous reset.
*/
// Operation
// - Coil code 01 positive, 10 negative, else off
// - Host passes through off between 01 and 10
// - Every conversion samples temperature, compensates field; the device compensates once per burst, on the averaged field
// - Select code 01 at 0xC3 routes temperature
// - Temperature read at 0xC1/0xC2, 15-bit unsigned
// - Temperature valid after single or burst
// - Burst averages field only, never temperature
// - Host code is high[6:0]*32 plus low>>3
// - Raw code uncorrected; corrections at 0x1D, 0x1E
// - Host offset byte/16, gain 1+byte/2048
// - Host final temp uses gain, offset, supply
// - Host computes correction terms once, may average
// - Load address, set trigger, auto-clear, data ready
package trc_pkg;

  // ----------------------------------------------------------------------
  // Device register map (link side)
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_RESULT_HIGH = 8'hC1;
  localparam logic [7:0] REG_RESULT_LOW = 8'hC2;
  localparam logic [7:0] REG_SOURCE_SEL = 8'hC3;
  localparam logic [7:0] REG_OTP_ADDR = 8'hE1;
  localparam logic [7:0] REG_OTP_DATA = 8'hE2;
  localparam logic [7:0] REG_OTP_CTRL = 8'hE3;
  localparam logic [7:0] REG_COIL = 8'hE4;
  localparam logic [7:0] REG_BURST = 8'hE5;
  localparam logic [7:0] REG_TEMPCO = 8'hE6;

  // Nonvolatile correction bytes
  localparam logic [7:0] OTP_TEMP_OFFSET = 8'h1D;
  localparam logic [7:0] OTP_TEMP_GAIN = 8'h1E;

  // Fields and codes
  localparam logic [2:0] SRC_FIELD = 3'h0;
  localparam logic [2:0] SRC_TEMP = 3'h1;
  localparam logic [1:0] COIL_OFF = 2'h0;
  localparam logic [1:0] COIL_POS = 2'h1;
  localparam logic [1:0] COIL_NEG = 2'h2;
  localparam int OTP_TRIG_BIT = 0;
  localparam int OTP_BUSY_BIT = 1;
  localparam int CODE_HIGH_SHIFT = 5;
  localparam int CODE_LOW_SHIFT = 3;

  // Reset values and temperature reference
  localparam logic [2:0] SOURCE_SEL_RESET = 3'h0;
  localparam logic [1:0] COIL_RESET = 2'h0;
  localparam logic [2:0] BURST_RESET = 3'h0;
  localparam logic [7:0] TEMPCO_RESET = 8'h00;
  localparam logic [15:0] TEMP_REF = 16'h4000;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OTP_READ_TIME_NS = 20;
  localparam logic [3:0] OTP_READ_CYCLES =
    4'((OTP_READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Host Wishbone register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam logic [7:0] HOST_COIL = 8'h08;
  localparam logic [7:0] HOST_TEMP = 8'h0C;
  localparam logic [7:0] HOST_CORR = 8'h10;

  typedef enum logic [1:0] {JOB_RAW, JOB_COIL, JOB_TEMP, JOB_CORR} trc_job_type;

endpackage : trc_pkg
